// file: hdl/usb_desc_cfg.svh
// Register offsets, field positions and reset values of the descriptor base and configuration bank.
`ifndef USB_DESC_CFG_SVH
`define USB_DESC_CFG_SVH
`define OFF_BASE_LOW 12'h000
`define OFF_BASE_MID 12'h004
`define OFF_BASE_HIGH 12'h008
`define OFF_CONFIG 12'h00C
`define OFF_STATUS 12'h010
`define LOW_MASK 8'hFE
`define CONFIG_MASK 8'hD1
`define BYTE_RESET 8'h00
`define BIT_EYE 7
`define BIT_OEMON 6
`define BIT_SIDL 4
`define BIT_ASUSP 0
`define ALIGN_ZERO 9'h000
`define READ_ZERO 32'h0000_0000
`define UPPER_ZERO 24'h00_0000
`define STATUS_PAD 28'h000_0000
`endif

// file: hdl/usb_desc_pkg.sv
// Types shared by the descriptor base and configuration bank.
package usb_desc_pkg;
  typedef enum logic [1:0]
  {
    SUSP_RUN = 2'b00,
    SUSP_AUTO = 2'b01,
    SUSP_SOFT = 2'b11
  } susp_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// file: hdl/bank_wr_if.sv
// Write strobes and data that pass from the bus slave to the register storage.
`timescale 1ns/1ps
interface bank_wr_if;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic wr_cfg;
  logic [7:0] wdata;
  modport src (output wr_low, output wr_mid, output wr_high, output wr_cfg, output wdata);
  modport dst (input wr_low, input wr_mid, input wr_high, input wr_cfg, input wdata);
endinterface

// file: hdl/sync2.sv
// Two-flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
module sync2 (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Level in and out.
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: hdl/usb_descriptor_base_and_config.sv
// Descriptor table base and configuration bank of a full-speed USB controller, APB slave.
//
// Overview of operation
// R01: The low base register keeps a writable 7-bit field in bits 7:1 giving base bits 15:9.
// R02: The mid base register keeps a writable byte giving base bits 23:16.
// R03: The high base register keeps a writable byte giving base bits 31:24.
// R04: The formed 32-bit table base always has bits 8:0 at zero, a 512-byte alignment.
// R05: Bit 0 of the low base register reads zero and ignores writes.
// R06: Bits 31:8 of all four registers read zero and ignore writes.
// R07: Configuration bit 7 enables the transceiver eye-pattern test, else it stays off.
// R08: Configuration bit 6 lets the drive indicator show when D+ and D- are driven.
// R09: Configuration bit 4 halts the module while the chip idles, else it runs on.
// R10: Configuration bit 0 makes the module suspend by itself when the chip sleeps.
// R11: Without auto-suspend only the software suspend bit suspends and stops the 48 MHz clock.
// R12: Implemented bits reset to zero and read back the last value written.
`timescale 1ns/1ps
`include "usb_desc_cfg.svh"
module usb_descriptor_base_and_config
  import usb_desc_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip power state and transceiver, from outside the clock domain.
  input wire logic chip_idle,
  input wire logic chip_sleep,
  input wire logic software_suspend,
  input wire logic xcvr_driving,
  // Controls to the rest of the controller.
  output logic [31:0] table_base,
  output logic eye_pattern_test_enable,
  output logic drive_indicator,
  output logic module_halted,
  output logic module_suspended,
  output logic usb_clk_enable
);
  import usb_desc_pkg::*;

  bank_wr_if wr ();
  reg_byte_t low_reg;
  reg_byte_t mid_reg;
  reg_byte_t high_reg;
  reg_byte_t cfg_reg;
  logic idle_s;
  logic sleep_s;
  logic soft_s;
  logic drive_s;
  logic access;
  logic decode_ok;
  logic [31:0] rdata_next;
  susp_state_t susp_reg;
  susp_state_t susp_next;

  // Pin levels pass two flip-flops before any logic reads them.
  sync2 u_sync_idle (.sys_clk(sys_clk), .rst_n(rst_n), .d(chip_idle), .q(idle_s));
  sync2 u_sync_sleep (.sys_clk(sys_clk), .rst_n(rst_n), .d(chip_sleep), .q(sleep_s));
  sync2 u_sync_soft (.sys_clk(sys_clk), .rst_n(rst_n), .d(software_suspend), .q(soft_s));
  sync2 u_sync_drive (.sys_clk(sys_clk), .rst_n(rst_n), .d(xcvr_driving), .q(drive_s));

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign access = psel && penable;

  // Address decode; unmapped addresses answer with an error and write nothing.
  always_comb
  begin
    decode_ok = 1'b1;
    rdata_next = `READ_ZERO;
    if (paddr == `OFF_BASE_LOW)
    begin
      rdata_next = {`UPPER_ZERO, low_reg};
    end
    else if (paddr == `OFF_BASE_MID)
    begin
      rdata_next = {`UPPER_ZERO, mid_reg};
    end
    else if (paddr == `OFF_BASE_HIGH)
    begin
      rdata_next = {`UPPER_ZERO, high_reg};
    end
    else if (paddr == `OFF_CONFIG)
    begin
      rdata_next = {`UPPER_ZERO, cfg_reg};
    end
    else if (paddr == `OFF_STATUS)
    begin
      // Read-only view of the power state so software can see the outcome.
      rdata_next = {`STATUS_PAD, usb_clk_enable, module_suspended,
        module_halted, drive_indicator};
    end
    else
    begin
      decode_ok = 1'b0;
    end
  end

  assign pslverr = access && !decode_ok;

  // Read data is captured in the setup cycle, so it comes from a flip-flop and
  // still stands for the whole zero-wait access phase.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= `READ_ZERO;
    end
    else if (psel && !penable)
    begin
      prdata <= rdata_next; // R06
    end
  end

  // Only the low byte of pwdata is stored; upper bits are dropped.
  assign wr.wdata = pwdata[7:0]; // R06
  assign wr.wr_low = access && pwrite && (paddr == `OFF_BASE_LOW);
  assign wr.wr_mid = access && pwrite && (paddr == `OFF_BASE_MID);
  assign wr.wr_high = access && pwrite && (paddr == `OFF_BASE_HIGH);
  assign wr.wr_cfg = access && pwrite && (paddr == `OFF_CONFIG);

  // Base register storage; bit 0 of the low byte is masked so it never holds a one.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_reg <= `BYTE_RESET; // R12
      mid_reg <= `BYTE_RESET;
      high_reg <= `BYTE_RESET;
    end
    else
    begin
      if (wr.wr_low)
      begin
        low_reg <= wr.wdata & `LOW_MASK; // R01 R05
      end
      if (wr.wr_mid)
      begin
        mid_reg <= wr.wdata; // R02
      end
      if (wr.wr_high)
      begin
        high_reg <= wr.wdata; // R03
      end
    end
  end

  // Configuration storage; unimplemented bits 5 and 3:1 stay zero.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= `BYTE_RESET; // R12
    end
    else if (wr.wr_cfg)
    begin
      cfg_reg <= wr.wdata & `CONFIG_MASK; // R12
    end
  end

  // Table base with the nine alignment bits forced low.
  assign table_base = {high_reg, mid_reg, low_reg[7:1], `ALIGN_ZERO}; // R04

  // Test and monitor controls, registered so they come from flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eye_pattern_test_enable <= 1'b0;
      drive_indicator <= 1'b0;
      module_halted <= 1'b0;
    end
    else
    begin
      eye_pattern_test_enable <= cfg_reg[`BIT_EYE]; // R07
      drive_indicator <= cfg_reg[`BIT_OEMON] && drive_s; // R08
      module_halted <= cfg_reg[`BIT_SIDL] && idle_s; // R09
    end
  end

  // Suspend state: software suspend wins, auto suspend follows sleep only if enabled.
  always_comb
  begin
    susp_next = SUSP_RUN;
    if (soft_s)
    begin
      susp_next = SUSP_SOFT; // R11
    end
    else if (cfg_reg[`BIT_ASUSP] && sleep_s)
    begin
      susp_next = SUSP_AUTO; // R10
    end
  end

  // Suspend state register; a cause that goes away lets the module run again.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      susp_reg <= SUSP_RUN;
    end
    else
    begin
      susp_reg <= susp_next;
    end
  end

  // A suspended module gates its 48 MHz clock off.
  always_comb
  begin
    case (susp_reg)
      SUSP_RUN:
      begin
        module_suspended = 1'b0;
      end
      default:
      begin
        module_suspended = 1'b1; // R10 R11
      end
    endcase
  end
  assign usb_clk_enable = !module_suspended; // R11

  // Checks on the observable behaviour.
  sequence s_low_write;
    psel && penable && pwrite && paddr == `OFF_BASE_LOW;
  endsequence

  sequence s_cfg_write;
    psel && penable && pwrite && paddr == `OFF_CONFIG;
  endsequence

  sequence s_status_write;
    psel && penable && pwrite && paddr == `OFF_STATUS;
  endsequence

  sequence s_read_setup;
    psel && !penable && !pwrite;
  endsequence

  sequence s_read_access;
    psel && penable && !pwrite;
  endsequence

  a_low_bit_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
    s_low_write |=> low_reg[0] == 1'b0)
    else $error("low base bit 0 became set");
  a_low_field: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
    s_low_write |=> low_reg[7:1] == $past(pwdata[7:1]))
    else $error("low base field not stored");
  a_mid_store: assert property (@(posedge sys_clk) disable iff (!rst_n) // R02
    psel && penable && pwrite && paddr == `OFF_BASE_MID |=> table_base[23:16] == $past(pwdata[7:0]))
    else $error("mid base byte not stored");
  a_high_store: assert property (@(posedge sys_clk) disable iff (!rst_n) // R03
    psel && penable && pwrite && paddr == `OFF_BASE_HIGH |=> table_base[31:24] == $past(pwdata[7:0]))
    else $error("high base byte not stored");
  a_base_align: assert property (@(posedge sys_clk) disable iff (!rst_n) // R04
    table_base[8:0] == `ALIGN_ZERO)
    else $error("table base not aligned");
  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // R06
    psel && penable && !pwrite && decode_ok && paddr != `OFF_STATUS |-> prdata[31:8] == `UPPER_ZERO)
    else $error("upper read bits not zero");
  a_eye_follow: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
    s_cfg_write ##2 1'b1
      |-> eye_pattern_test_enable == $past(pwdata[`BIT_EYE], 2))
    else $error("eye test enable does not follow config");
  a_drive_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
    !cfg_reg[`BIT_OEMON] |=> !drive_indicator)
    else $error("drive indicator active while disabled");
  a_idle_halt: assert property (@(posedge sys_clk) disable iff (!rst_n) // R09
    !cfg_reg[`BIT_SIDL] |=> !module_halted)
    else $error("halted without stop in idle");
  a_no_auto: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    !cfg_reg[`BIT_ASUSP] && !soft_s |=> !module_suspended && usb_clk_enable)
    else $error("suspended without a cause");
  a_auto_susp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    cfg_reg[`BIT_ASUSP] && sleep_s |=> module_suspended)
    else $error("no auto suspend on sleep");
  a_cfg_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    psel && penable && !pwrite && paddr == `OFF_CONFIG |-> prdata[7:0] == cfg_reg)
    else $error("config readback mismatch");
  a_mid_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    psel && penable && !pwrite && paddr == `OFF_BASE_MID |-> prdata == {`UPPER_ZERO, mid_reg})
    else $error("mid base readback mismatch");
  a_read_upper: assert property (@(posedge sys_clk) disable iff (!rst_n) // R06
    s_read_setup ##1 s_read_access |-> prdata[31:8] == `UPPER_ZERO)
    else $error("upper read bits not zero after setup");
  a_cfg_unused: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    s_cfg_write |=> (cfg_reg & ~`CONFIG_MASK) == `BYTE_RESET)
    else $error("unimplemented config bit became set");
  a_status_ro: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    s_status_write |=> $stable(table_base) && $stable(cfg_reg))
    else $error("status write disturbed a register");
  a_drive_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
    cfg_reg[`BIT_OEMON] && drive_s |=> drive_indicator)
    else $error("drive indicator missing while enabled");
  a_halt_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R09
    cfg_reg[`BIT_SIDL] && idle_s |=> module_halted)
    else $error("not halted in idle with stop in idle");
  a_soft_susp: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    soft_s |=> module_suspended && !usb_clk_enable)
    else $error("software suspend not obeyed");
endmodule

// file: tb/test_usb_descriptor_base_and_config.sv
// Self-checking bench for the descriptor base and configuration register bank.
`timescale 1ns/1ps
`include "usb_desc_cfg.svh"
module test_usb_descriptor_base_and_config;
  import usb_desc_pkg::*;
  typedef struct {logic [11:0] addr; logic [31:0] wdata; logic [31:0] rexp; logic [31:0] bexp;} row_t;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, table_base, rd;
  logic chip_idle, chip_sleep, software_suspend, xcvr_driving, er;
  logic eye_pattern_test_enable, drive_indicator, module_halted, module_suspended, usb_clk_enable;
  int num_errors = 0;
  int checks = 0;
  row_t rows [4];

  usb_descriptor_base_and_config u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_idle(chip_idle), .chip_sleep(chip_sleep),
    .software_suspend(software_suspend), .xcvr_driving(xcvr_driving), .table_base(table_base),
    .eye_pattern_test_enable(eye_pattern_test_enable), .drive_indicator(drive_indicator),
    .module_halted(module_halted), .module_suspended(module_suspended),
    .usb_clk_enable(usb_clk_enable));

  // Free-running 125 MHz system clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sets the outside levels, then waits out the two-stage sync and the output register.
  task automatic pins(input logic i, input logic s, input logic ss, input logic x);
    @(posedge sys_clk);
    chip_idle <= i;
    chip_sleep <= s;
    software_suspend <= ss;
    xcvr_driving <= x;
    repeat (5) @(posedge sys_clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs about a hundred cycles.
  initial
  begin
    #(8 * 5000);
    num_errors++;
    wrap_up();
  end

  // Main sequence: table rows first, then the awkward cases by hand.
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, chip_idle, chip_sleep, software_suspend, xcvr_driving} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rows[0] = '{`OFF_BASE_LOW, 32'hFFFF_FFFF, 32'h0000_00FE, 32'h0000_FE00};
    rows[1] = '{`OFF_BASE_MID, 32'hFFFF_FFA5, 32'h0000_00A5, 32'h00A5_FE00};
    rows[2] = '{`OFF_BASE_HIGH, 32'h1234_5678, 32'h0000_0078, 32'h78A5_FE00};
    rows[3] = '{`OFF_CONFIG, 32'hFFFF_FFFF, 32'h0000_00D1, 32'h78A5_FE00};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("clk_enable_at_reset", 32'h1, {31'h0, usb_clk_enable});
    foreach (rows[k])
    begin
      apb(1'b0, rows[k].addr, 32'h0000_0000);
      chk("reset_value", 32'h0000_0000, rd);
      apb(1'b1, rows[k].addr, rows[k].wdata);
      apb(1'b0, rows[k].addr, 32'h0000_0000);
      chk("readback", rows[k].rexp, rd);
      chk("table_base", rows[k].bexp, table_base);
    end
    // Bit 0 of the low base written alone must not leak into the base.
    apb(1'b1, `OFF_BASE_LOW, 32'h0000_0001);
    apb(1'b0, `OFF_BASE_LOW, 32'h0000_0000);
    chk("low_bit0", 32'h0000_0000, rd);
    chk("base_align", 32'h78A5_0000, table_base);
    // All four controls set: eye test on, indicator follows the transceiver.
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    chk("eye_on", 32'h1, {31'h0, eye_pattern_test_enable});
    chk("indicator_idle", 32'h0, {31'h0, drive_indicator});
    chk("halted_on", 32'h1, {31'h0, module_halted});
    chk("auto_susp", 32'h1, {31'h0, module_suspended});
    chk("clk_off", 32'h0, {31'h0, usb_clk_enable});
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chk("indicator_on", 32'h1, {31'h0, drive_indicator});
    chk("halted_run", 32'h0, {31'h0, module_halted});
    chk("wake", 32'h0, {31'h0, module_suspended});
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    chk("status_drive", 32'h0000_0009, rd);
    // Controls cleared: sleep alone must not suspend, only the software bit does.
    apb(1'b1, `OFF_CONFIG, 32'h0000_0000);
    pins(1'b1, 1'b1, 1'b0, 1'b1);
    chk("eye_off", 32'h0, {31'h0, eye_pattern_test_enable});
    chk("indicator_off", 32'h0, {31'h0, drive_indicator});
    chk("idle_runs", 32'h0, {31'h0, module_halted});
    chk("no_auto_susp", 32'h0, {31'h0, module_suspended});
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    chk("soft_susp", 32'h1, {31'h0, module_suspended});
    chk("soft_clk_off", 32'h0, {31'h0, usb_clk_enable});
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    chk("status_soft", 32'h0000_0004, rd);
    apb(1'b1, `OFF_STATUS, 32'hFFFF_FFFF);
    chk("status_wr_no_err", 32'h0, {31'h0, er});
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    // An unmapped word answers with an error and reads zero.
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped_data", 32'h0000_0000, rd);
    // A second reset in mid-run clears every register again.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("base_after_reset", 32'h0000_0000, table_base);
    apb(1'b0, `OFF_BASE_HIGH, 32'h0000_0000);
    chk("high_after_reset", 32'h0000_0000, rd);
    wrap_up();
  end
endmodule
